// [design/vram_ctl.sv]
// host-side strobe sequencer for a dual-port video dram
`timescale 1ns/1ps
`include "vram_ctl_regs.svh"

// Contract
// - Nine-bit row address stable on the pins when row strobe falls.
// - Nine-bit column address stable when the first column strobe falls.
// - Split tap on bits zero-six, never 127, 255 or a stop location.
// - Issue a stop-point refresh right after power-up when using stops.
module vram_ctl
  import vram_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // user command port
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire cmd_s        CMD,
  output logic             CMD_ERR,
  input  wire logic        STOP_USE,
  // user read data
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic [15:0]      RD_DATA,
  // user serial port
  input  wire logic        SER_RUN,
  input  wire logic        SER_OE,
  output logic             SER_VALID,
  output logic [15:0]      SER_DATA,
  output logic             SER_HALF,
  // device parallel pins
  output logic             RAS_N,
  output logic             COL_STROBE_LOW_BYTE_N,
  output logic             COL_STROBE_HIGH_BYTE_N,
  output logic             TRANSFER_SELECT_OE_N,
  output logic             WE_N,
  output logic             SPECIAL_FUNCTION_SELECT,
  output logic [8:0]       MUX_ADDRESS_IN,
  input  wire logic [15:0] PARALLEL_DATA_IO_I,
  output logic [15:0]      PARALLEL_DATA_IO_O,
  output logic             PARALLEL_DATA_IO_OE,
  // device serial pins
  output logic             SERIAL_CLOCK,
  output logic             SERIAL_OUTPUT_ENABLE_N,
  input  wire logic [15:0] SERIAL_DATA_OUT,
  input  wire logic        SERIAL_HALF_INDICATOR
);
  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_CBR, S_ROW, S_RAS, S_COL, S_CAS, S_DATA, S_PRE
  } st_e;
  localparam logic [3:0] PH_LAST = 4'(`PHASE_CYC - 1);

  st_e         st_r;
  logic [3:0]  ph_r;
  cmd_s        cur_r;
  logic        init_r;
  logic        persist_r;
  logic        stop_mode_r;
  logic        fifo_rdy;
  logic        push;
  logic        ph_end;
  logic        is_ref;
  logic        is_xfer;
  logic        is_wr;
  logic        bad_tap;
  logic        accept;

  assign ph_end  = (ph_r == PH_LAST);
  assign is_ref  = cur_r.op inside {OP_REF_RESET, OP_REF_NORESET, OP_REF_STOP};
  assign is_xfer = cur_r.op inside {OP_FULL_XFER, OP_SPLIT_XFER};
  assign is_wr   = !(is_xfer || is_ref || cur_r.op == OP_READ);
  // never start a read without room for its word
  assign CMD_READY = (st_r == S_IDLE) && !init_r
                     && (CMD.op != OP_READ || fifo_rdy);
  assign accept    = CMD_VALID && CMD_READY;
  // refuse split taps that the part cannot stop on
  assign bad_tap   = (CMD.op == OP_SPLIT_XFER)
                     && (CMD.col[6:0] == `SPLIT_BAD
                     || (stop_mode_r && CMD.col[3:0] == 4'hf));
  assign push      = (st_r == S_DATA) && ph_end && (cur_r.op == OP_READ);

  // state and phase counter
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r    <= S_IDLE;
      ph_r    <= 4'h0;
      init_r  <= 1'b1;
      cur_r   <= '0;
      CMD_ERR <= 1'b0;
    end else begin
      CMD_ERR <= 1'b0;
      ph_r    <= ph_end ? 4'h0 : ph_r + 4'h1;
      unique case (st_r)
        S_IDLE: begin
          ph_r <= 4'h0;
          if (init_r) begin
            init_r <= 1'b0;
            if (STOP_USE) begin
              cur_r    <= '0;
              cur_r.op <= OP_REF_STOP;
              st_r     <= S_CBR;
            end
          end else if (accept && bad_tap) begin
            CMD_ERR <= 1'b1;
          end else if (accept) begin
            cur_r <= CMD;
            st_r  <= (CMD.op inside {OP_REF_RESET, OP_REF_NORESET,
                      OP_REF_STOP}) ? S_CBR : S_ROW;
          end
        end
        S_CBR:  if (ph_end) st_r <= S_RAS;
        S_ROW:  if (ph_end) st_r <= S_RAS;
        S_RAS:  if (ph_end) st_r <= is_ref ? S_PRE : S_COL;
        S_COL:  if (ph_end) st_r <= S_CAS;
        S_CAS:  if (ph_end) st_r <= S_DATA;
        S_DATA: if (ph_end) st_r <= S_PRE;
        S_PRE:  if (ph_end) st_r <= S_IDLE;
      endcase
    end
  end

  // mirror of the device's persistent and stop modes
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      persist_r   <= 1'b0;
      stop_mode_r <= 1'b0;
    end else if (st_r == S_PRE && ph_end) begin
      if (cur_r.op == OP_MASK_LOAD) persist_r <= 1'b1;
      if (cur_r.op == OP_REF_STOP) stop_mode_r <= 1'b1;
      if (cur_r.op == OP_REF_RESET) begin
        persist_r   <= 1'b0;
        stop_mode_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // pin decode, registered one cycle behind the state
  // -----------------------------------------------------------------
  logic        ras_nxt;
  logic [1:0]  cas_nxt;
  logic        trg_nxt;
  logic        we_nxt;
  logic        dsf_nxt;
  logic [8:0]  addr_nxt;
  logic [15:0] dq_nxt;
  logic        oe_nxt;
  logic        mwr;
  logic        row_ph;
  logic        col_ph;

  always_comb begin
    mwr      = cur_r.op == OP_MASKED_WRITE
               || (cur_r.op == OP_BLOCK_WRITE && cur_r.masked);
    row_ph   = (st_r == S_ROW) || (st_r == S_RAS && !is_ref);
    col_ph   = st_r inside {S_COL, S_CAS, S_DATA};
    ras_nxt  = !(st_r inside {S_RAS, S_COL, S_CAS, S_DATA});
    cas_nxt  = 2'b11;
    trg_nxt  = 1'b1;
    we_nxt   = 1'b1;
    dsf_nxt  = 1'b0;
    addr_nxt = MUX_ADDRESS_IN;
    dq_nxt   = PARALLEL_DATA_IO_O;
    oe_nxt   = 1'b0;
    if (st_r == S_CBR || (st_r == S_RAS && is_ref)) begin
      // column strobes fall ahead of the row strobe for refresh
      cas_nxt  = 2'b00;
      we_nxt   = (cur_r.op != OP_REF_STOP);
      dsf_nxt  = (cur_r.op != OP_REF_RESET);
      addr_nxt = 9'({cur_r.stop_code, 4'h0});
    end else if (row_ph) begin
      addr_nxt = cur_r.row;
      trg_nxt  = !is_xfer;
      we_nxt   = !mwr;
      dsf_nxt  = cur_r.op inside {OP_MASK_LOAD, OP_COLOUR_LOAD,
                 OP_SPLIT_XFER};
      // fresh mask rides the data pins unless the stored one persists
      oe_nxt   = mwr && !persist_r;
      dq_nxt   = cur_r.mask;
    end else if (col_ph) begin
      addr_nxt = cur_r.col;
      dsf_nxt  = cur_r.op inside {OP_BLOCK_WRITE, OP_COLOUR_LOAD};
      we_nxt   = !is_wr;
      oe_nxt   = is_wr;
      dq_nxt   = cur_r.data;
      trg_nxt  = is_xfer ? (st_r == S_DATA)
                 : !(cur_r.op == OP_READ && st_r != S_COL);
      if (st_r != S_COL) begin
        cas_nxt = is_xfer ? 2'b00 : ~cur_r.byte_en;
      end
    end
  end

  // parallel pin flops
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RAS_N                   <= 1'b1;
      COL_STROBE_LOW_BYTE_N   <= 1'b1;
      COL_STROBE_HIGH_BYTE_N  <= 1'b1;
      TRANSFER_SELECT_OE_N    <= 1'b1;
      WE_N                    <= 1'b1;
      SPECIAL_FUNCTION_SELECT <= 1'b0;
      MUX_ADDRESS_IN          <= 9'h000;
      PARALLEL_DATA_IO_O      <= 16'h0000;
      PARALLEL_DATA_IO_OE     <= 1'b0;
    end else begin
      RAS_N                   <= ras_nxt;
      COL_STROBE_LOW_BYTE_N   <= cas_nxt[0];
      COL_STROBE_HIGH_BYTE_N  <= cas_nxt[1];
      TRANSFER_SELECT_OE_N    <= trg_nxt;
      WE_N                    <= we_nxt;
      SPECIAL_FUNCTION_SELECT <= dsf_nxt;
      MUX_ADDRESS_IN          <= addr_nxt;
      PARALLEL_DATA_IO_O      <= dq_nxt;
      PARALLEL_DATA_IO_OE     <= oe_nxt;
    end
  end

  // read words wait here so a slow consumer stalls new reads
  rd_fifo #(.W(16), .D(`RD_DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (PARALLEL_DATA_IO_I),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );

  // -----------------------------------------------------------------
  // serial port
  // -----------------------------------------------------------------
  logic [3:0] sc_cnt_r;

  // divided serial clock; each rise steps the device's counter
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sc_cnt_r     <= 4'h0;
      SERIAL_CLOCK <= 1'b0;
    end else if (SER_RUN || SERIAL_CLOCK) begin
      sc_cnt_r <= (sc_cnt_r == `SC_HALF_CYC - 4'h1) ? 4'h0 : sc_cnt_r + 4'h1;
      if (sc_cnt_r == `SC_HALF_CYC - 4'h1) begin
        SERIAL_CLOCK <= !SERIAL_CLOCK;
      end
    end
  end

  // sample the word one half period after each rise
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SERIAL_OUTPUT_ENABLE_N <= 1'b1;
      SER_VALID              <= 1'b0;
      SER_DATA               <= 16'h0000;
      SER_HALF               <= 1'b0;
    end else begin
      SERIAL_OUTPUT_ENABLE_N <= !SER_OE;
      SER_VALID <= 1'b0;
      if (SERIAL_CLOCK && sc_cnt_r == `SC_HALF_CYC - 4'h1
          && !SERIAL_OUTPUT_ENABLE_N) begin
        SER_VALID <= 1'b1;
        SER_DATA  <= SERIAL_DATA_OUT;
        SER_HALF  <= SERIAL_HALF_INDICATOR;
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  logic seen_ras_r;
  always_ff @(posedge MCLK) begin
    if (!RST_N) seen_ras_r <= 1'b0;
    else if (!RAS_N) seen_ras_r <= 1'b1;
  end

  sequence s_ras_fall;
    $fell(RAS_N);
  endsequence
  sequence s_cas_first;
    RAS_N == 1'b0 && $fell(COL_STROBE_LOW_BYTE_N & COL_STROBE_HIGH_BYTE_N);
  endsequence

  property p_row_stable;
    @(posedge MCLK) disable iff (!RST_N)
    s_ras_fall |-> $stable(MUX_ADDRESS_IN) && $past(RAS_N);
  endproperty
  a_row_stable: assert property (p_row_stable)
    else $error("row address moved at row strobe fall");

  property p_col_stable;
    @(posedge MCLK) disable iff (!RST_N)
    s_cas_first |-> $stable(MUX_ADDRESS_IN) && $stable(RAS_N);
  endproperty
  a_col_stable: assert property (p_col_stable)
    else $error("column address moved at column strobe fall");

  property p_split_tap;
    @(posedge MCLK) disable iff (!RST_N)
    s_cas_first ##0 (cur_r.op == OP_SPLIT_XFER)
      |-> MUX_ADDRESS_IN[6:0] != `SPLIT_BAD;
  endproperty
  a_split_tap: assert property (p_split_tap)
    else $error("illegal split tap issued");

  property p_init_stop;
    @(posedge MCLK) disable iff (!RST_N)
    s_ras_fall ##0 (!seen_ras_r && STOP_USE)
      |-> !COL_STROBE_LOW_BYTE_N && !WE_N && SPECIAL_FUNCTION_SELECT;
  endproperty
  a_init_stop: assert property (p_init_stop)
    else $error("first cycle after reset was not a stop-point refresh");

  property p_cbr_order;
    @(posedge MCLK) disable iff (!RST_N)
    s_ras_fall ##0 !COL_STROBE_LOW_BYTE_N
      |-> $past(!COL_STROBE_LOW_BYTE_N, 2) && TRANSFER_SELECT_OE_N;
  endproperty
  a_cbr_order: assert property (p_cbr_order)
    else $error("column strobe did not lead row strobe for refresh");

  property p_xfer_sel;
    @(posedge MCLK) disable iff (!RST_N)
    s_ras_fall ##0 COL_STROBE_LOW_BYTE_N |-> TRANSFER_SELECT_OE_N == !is_xfer;
  endproperty
  a_xfer_sel: assert property (p_xfer_sel)
    else $error("transfer select wrong at row strobe fall");

  property p_read_bus;
    @(posedge MCLK) disable iff (!RST_N)
    push |-> !PARALLEL_DATA_IO_OE && !RAS_N && !TRANSFER_SELECT_OE_N;
  endproperty
  a_read_bus: assert property (p_read_bus)
    else $error("read data taken while bus not in read state");

  property p_persist;
    @(posedge MCLK) disable iff (!RST_N)
    (st_r == S_PRE && ph_end && cur_r.op == OP_MASK_LOAD) |=> persist_r;
  endproperty
  a_persist: assert property (p_persist)
    else $error("mask load did not enter persistent mode");

  property p_ser_step;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(SERIAL_CLOCK) && !SERIAL_OUTPUT_ENABLE_N |-> ##[1:3] SER_VALID;
  endproperty
  a_ser_step: assert property (p_ser_step)
    else $error("serial word not sampled after clock rise");
endmodule

// [design/vram_ctl_regs.svh]
// timing and field constants for the video dram host controller
`ifndef VRAM_CTL_REGS_SVH
`define VRAM_CTL_REGS_SVH

// clock period and least strobe phase time
`define MCLK_NS      25
`define T_PHASE_NS   30
`define PHASE_CYC    ((`T_PHASE_NS + `MCLK_NS - 1) / `MCLK_NS)
// serial clock half period in mclk cycles
`define SC_HALF_CYC  4'h2
// split-transfer tap that is never legal (127 and 255)
`define SPLIT_BAD    7'h7f
// stop-point code field on the address pins
`define STOP_LSB     4
// read fifo depth
`define RD_DEPTH     8

`endif

// [design/vram_ctl_pkg.sv]
// types shared by the video dram host controller
package vram_ctl_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_MASKED_WRITE, OP_BLOCK_WRITE,
    OP_MASK_LOAD, OP_COLOUR_LOAD, OP_FULL_XFER, OP_SPLIT_XFER,
    OP_REF_RESET, OP_REF_NORESET, OP_REF_STOP
  } op_e;

  typedef struct packed {
    op_e         op;
    logic [8:0]  row;
    logic [8:0]  col;
    logic [15:0] data;
    logic [15:0] mask;
    logic [1:0]  byte_en;
    logic        masked;
    logic [3:0]  stop_code;
  } cmd_s;
endpackage

// [design/rd_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rd_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  // storage written by index
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [sim/vram_dev_model.sv]
// behavioural model of the dual-port video dram seen by the controller
`timescale 1ns/1ps
module vram_dev_model (
  // parallel port
  input  wire logic        ras_n,
  input  wire logic        cas_lo_n,
  input  wire logic        cas_hi_n,
  input  wire logic        trg_n,
  input  wire logic        we_n,
  input  wire logic        special_function_select,
  input  wire logic [8:0]  addr,
  input  wire logic [15:0] dq,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  // serial port
  input  wire logic        sc,
  input  wire logic        se_n,
  output logic [15:0]      sq,
  output logic             serial_half_indicator
);
  logic [15:0] mem [262144];
  logic [15:0] serial_register [256];
  logic [15:0] wm, wmask, colour;
  logic [8:0]  row, col;
  logic [7:0]  cnt = 8'h0;
  logic        refr, xfer, dsf_r, dsf_c;
  logic        persist = 1'b0;
  logic        stop_mode = 1'b0;
  wire         cas_n = cas_lo_n & cas_hi_n;  // low once either strobe is low
  initial foreach (mem[i]) mem[i] = 16'h0;
  // cycle decode at the row strobe fall
  always @(negedge ras_n) begin
    refr  = !cas_n;
    xfer  = !trg_n;
    dsf_r = special_function_select;
    row   = addr;
    wm    = we_n ? 16'hffff : (persist ? wmask : dq);
    if (refr && we_n && !special_function_select) begin
      persist   = 1'b0;
      stop_mode = 1'b0;
    end
    if (refr && !we_n && special_function_select)
      stop_mode = 1'b1;
  end
  // mask is per pin and per byte lane
  function automatic void put(input logic [17:0] a, input logic [15:0] d,
                              input logic [15:0] m);
    mem[a] = (mem[a] & ~m) | (d & m);
  endfunction
  task automatic take(input logic [15:0] d);
    logic [15:0] be;
    be = {{8{!cas_hi_n}}, {8{!cas_lo_n}}};
    if (dsf_r && dsf_c)
      colour = (colour & ~be) | (d & be);
    else if (dsf_r) begin
      wmask   = (wmask & ~be) | (d & be);
      persist = 1'b1;
    end else if (dsf_c) begin
      for (int k = 0; k < 4; k++)
        if (d[k]) put({row, col[8:2], 2'(k)}, colour, wm & be);
    end else
      put({row, col}, d, wm & be);
  endtask
  // split loads only the idle half so the running half keeps streaming
  task automatic load_sam();
    for (int i = 0; i < 256; i++)
      if (!dsf_r || i[7] != cnt[7]) serial_register[i] = mem[{row, col[8], 8'(i)}];
    if (!dsf_r) cnt = col[7:0];
  endtask
  // first column strobe fall and late write enable
  always @(negedge cas_n)
    if (!ras_n && !refr) begin
      col   = addr;
      dsf_c = special_function_select;
      if (xfer) load_sam();
      else if (!we_n) take(dq);
    end
  always @(negedge we_n)
    if (!ras_n && !cas_n && !refr && !xfer) take(dq);
  assign dq_oe  = !ras_n && !cas_n && !trg_n && we_n && !xfer && !refr;
  assign dq_out = mem[{row, col}];
  // serial side; a disabled port shows no stale word
  always @(posedge sc) cnt = cnt + 8'h1;
  assign sq  = se_n ? ~serial_register[cnt] : serial_register[cnt];
  assign serial_half_indicator = se_n ? ~cnt[7] : cnt[7];
endmodule

// [sim/vram_ctl_tb_top.sv]
// self-checking bench for the video dram host controller
`timescale 1ns/1ps
module vram_ctl_tb_top;
  import vram_ctl_pkg::*;
  logic        mclk, rst_n, cmd_valid, stop_use, rd_ready, ser_run, ser_oe;
  cmd_s        cmd, c;
  logic        cmd_ready, cmd_err, rd_valid, ser_valid, ser_half, persist;
  logic        ras_n, cl_n, ch_n, trg_n, we_n, special_function_select, dq_oe, dev_oe, sc, se_n, serial_half_indicator;
  logic [8:0]  addr;
  logic [15:0] rd_data, ser_data, dq_o, dq_bus, dev_out, sq, noise;
  logic [15:0] pmask, colour;
  logic [15:0] rm [int];
  logic [16:0] rq [$];
  logic [16:0] sq_q [$];
  int          failures, checked, cycles, errs;
  // split taps tried after the start-up stop refresh, and a tap walk
  logic [8:0]  bad_col [4] = '{9'h07f, 9'h1ff, 9'h00f, 9'h105};
  logic [7:0]  walk [4] = '{8'hfe, 8'hff, 8'h00, 8'h01};
  // a floating bus shows changing junk, never the last value
  assign dq_bus = dq_oe ? dq_o : (dev_oe ? dev_out : noise);
  vram_ctl uut (.MCLK(mclk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD(cmd), .CMD_ERR(cmd_err), .STOP_USE(stop_use),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
    .SER_RUN(ser_run), .SER_OE(ser_oe), .SER_VALID(ser_valid),
    .SER_DATA(ser_data), .SER_HALF(ser_half), .RAS_N(ras_n),
    .COL_STROBE_LOW_BYTE_N(cl_n), .COL_STROBE_HIGH_BYTE_N(ch_n),
    .TRANSFER_SELECT_OE_N(trg_n), .WE_N(we_n), .SPECIAL_FUNCTION_SELECT(special_function_select),
    .MUX_ADDRESS_IN(addr), .PARALLEL_DATA_IO_I(dq_bus),
    .PARALLEL_DATA_IO_O(dq_o), .PARALLEL_DATA_IO_OE(dq_oe),
    .SERIAL_CLOCK(sc), .SERIAL_OUTPUT_ENABLE_N(se_n), .SERIAL_DATA_OUT(sq),
    .SERIAL_HALF_INDICATOR(serial_half_indicator));
  vram_dev_model dev (.ras_n(ras_n), .cas_lo_n(cl_n), .cas_hi_n(ch_n),
    .trg_n(trg_n), .we_n(we_n), .special_function_select(special_function_select), .addr(addr), .dq(dq_bus),
    .dq_out(dev_out), .dq_oe(dev_oe), .sc(sc), .se_n(se_n), .sq(sq), .serial_half_indicator(serial_half_indicator));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // checking helpers and reference model
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [16:0] exp,
                     input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] rget(input int a);
    return rm.exists(a) ? rm[a] : 16'h0;
  endfunction
  function automatic cmd_s mk(input op_e op, input logic [8:0] r, co,
      input logic [15:0] d, m, input logic [1:0] be, input logic bm);
    return '{op: op, row: r, col: co, data: d, mask: m, byte_en: be,
             masked: bm, stop_code: 4'h0};
  endfunction
  // expectations follow the documented cycle functions only
  function automatic void model(input cmd_s x);
    logic [15:0] m;
    m = (x.op == OP_MASKED_WRITE || x.masked) ? (persist ? pmask : x.mask)
                                               : 16'hffff;
    m = m & {{8{x.byte_en[1]}}, {8{x.byte_en[0]}}};
    case (x.op)
      OP_READ:        rq.push_back({1'b0, rget({x.row, x.col})});
      OP_WRITE, OP_MASKED_WRITE:
        rm[{x.row, x.col}] = (rget({x.row, x.col}) & ~m) | (x.data & m);
      OP_BLOCK_WRITE:
        for (int k = 0; k < 4; k++)
          if (x.data[k]) rm[{x.row, x.col[8:2], 2'(k)}] =
            (rget({x.row, x.col[8:2], 2'(k)}) & ~m) | (colour & m);
      OP_MASK_LOAD: begin
        pmask   = x.data;
        persist = 1'b1;
      end
      OP_COLOUR_LOAD: colour = x.data;
      OP_REF_RESET:   persist = 1'b0;
      default: ;
    endcase
  endfunction
  task automatic run(input cmd_s x);
    int n;
    n = 0;
    model(x);
    // ready depends on the offered op, so offer it before waiting
    cmd = x;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #2 n++;
    end
    if (n == 400) chk("cmd_ready", 17'h1, 17'h0);
    cmd_valid = 1'b1;
    @(posedge mclk);
    #2 cmd_valid = 1'b0;
    // let an edge pass so a refused command is not re-raised at once
    @(posedge mclk);
    #2;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((rq.size() != 0 || sq_q.size() != 0) && n < 3000) begin
      @(posedge mclk);
      #2 n++;
    end
    if (n == 3000) chk("drain", 17'h0, 17'h1);
  endtask
  // result monitors and the hang guard
  always @(posedge mclk) begin
    noise <= 16'($urandom);
    cycles++;
    if (cmd_err === 1'b1) errs++;
    if (rd_valid === 1'b1 && rd_ready)
      chk("rd_data", rq.size() ? rq.pop_front() : 17'h1ffff, {1'b0, rd_data});
    if (ser_valid === 1'b1 && sq_q.size())
      chk("ser_word", sq_q.pop_front(), {ser_half, ser_data});
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(52117));
    {rst_n, cmd_valid, ser_run, ser_oe, persist} = '0;
    {stop_use, rd_ready} = 2'b11;
    {failures, checked, cycles, errs} = '0;
    cmd = '0;
    colour = 16'h0;
    pmask = 16'hffff;
    repeat (20) @(posedge mclk);
    #2 rst_n = 1'b1;
    // init ran a stop refresh: bad taps refused, a good one accepted
    for (int i = 0; i < 4; i++)
      run(mk(OP_SPLIT_XFER, 9'h001, bad_col[i],
             16'h0, 16'h0, 2'b11, 1'b0));
    repeat (20) @(posedge mclk);
    chk("split_refused", 17'd3, 17'(errs));
    for (int i = 0; i < 6; i++) begin
      c = mk(OP_WRITE, 9'($urandom), 9'($urandom), 16'($urandom), 16'h0,
             2'($urandom_range(3, 1)), 1'b0);
      run(c);
      run(mk(OP_READ, c.row, c.col, 16'h0, 16'h0, 2'b11, 1'b0));
    end
    run(mk(OP_WRITE, 9'h010, 9'h020, 16'h1234, 16'h0, 2'b11, 1'b0));
    run(mk(OP_MASKED_WRITE, 9'h010, 9'h020, 16'habcd, 16'h0ff0, 2'b11, 1'b0));
    run(mk(OP_MASK_LOAD, 9'h011, 9'h0, 16'hf00f, 16'hf00f, 2'b11, 1'b0));
    run(mk(OP_REF_NORESET, 9'h0, 9'h0, 16'h0, 16'h0, 2'b11, 1'b0));
    run(mk(OP_MASKED_WRITE, 9'h010, 9'h021, 16'h5a5a, 16'hffff, 2'b11, 1'b0));
    run(mk(OP_COLOUR_LOAD, 9'h011, 9'h0, 16'h7e7e, 16'h7e7e, 2'b11, 1'b0));
    run(mk(OP_BLOCK_WRITE, 9'h012, 9'h046, 16'h000d, 16'h0, 2'b11, 1'b0));
    run(mk(OP_REF_RESET, 9'h0, 9'h0, 16'h0, 16'h0, 2'b11, 1'b0));
    run(mk(OP_MASKED_WRITE, 9'h010, 9'h022, 16'h9999, 16'h00ff, 2'b11, 1'b0));
    for (int k = 0; k < 7; k++)
      run(mk(OP_READ, k < 3 ? 9'h010 : 9'h012, k < 3 ? 9'(9'h020 + k)
             : 9'(9'h041 + k), 16'h0, 16'h0, 2'b11, 1'b0));
    run(mk(OP_SPLIT_XFER, 9'h001, 9'h00f, 16'h0, 16'h0, 2'b11, 1'b0));
    repeat (20) @(posedge mclk);
    chk("stop_cleared", 17'd3, 17'(errs));
    // full transfer whose tap walks across the half boundary
    for (int i = 0; i < 4; i++)
      run(mk(OP_WRITE, 9'h030, {1'b1, walk[i]},
             16'($urandom), 16'h0, 2'b11, 1'b0));
    ser_oe = 1'b1;
    run(mk(OP_FULL_XFER, 9'h030, 9'h1fd, 16'h0, 16'h0, 2'b11, 1'b0));
    for (int k = 1; k < 5; k++)
      sq_q.push_back({1'(8'(8'hfd + k) >> 7),
                      rget({9'h030, 1'b1, 8'(8'hfd + k)})});
    // the transfer must load the serial register before the first rise
    repeat (16) @(posedge mclk);
    #2 ser_run = 1'b1;
    drain();
    ser_run = 1'b0;
    // read buffer filled until it refuses, then drained
    rd_ready = 1'b0;
    for (int k = 0; k < 9; k++) begin
      if (k == 8) begin
        repeat (24) @(posedge mclk);
        #2 cmd = mk(OP_READ, 9'h030, 9'h1ff, 16'h0, 16'h0, 2'b11, 1'b0);
        cmd_valid = 1'b1;
        repeat (6) @(posedge mclk);
        #2 chk("full_refuses", 17'h0, {16'h0, cmd_ready});
        cmd_valid = 1'b0;
        rd_ready = 1'b1;
      end
      run(mk(OP_READ, 9'h030, {1'b1, 8'(k)}, 16'h0, 16'h0, 2'b11, 1'b0));
    end
    drain();
    c = mk(OP_REF_STOP, 9'h0, 9'h0, 16'h0, 16'h0, 2'b11, 1'b0);
    c.stop_code = 4'h3;
    run(c);
    run(mk(OP_SPLIT_XFER, 9'h001, 9'h03f, 16'h0, 16'h0, 2'b11, 1'b0));
    repeat (20) @(posedge mclk);
    chk("stop_set", 17'd4, 17'(errs));
    final_report();
  end
endmodule
